/* sim/slow_port_bench.sv */
// Self-checking bench for the slow oscillator input port
`timescale 1ns/1ns
`default_nettype none

module slow_port_bench
    import slow_port_pkg::*;
;
    logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, run_clk;
    logic [ADR_W-1:0] wb_adr_i;
    logic [SEL_W-1:0] wb_sel_i;
    logic [DAT_W-1:0] wb_dat_i, wb_dat_o, rd;
    logic [1:0] osc_mode, lvl;
    logic wb_ack_o, wb_err_o, er, pout, poe, xen, xclk, ia, ib, p0;
    wire logic pa, pb;
    int failures, compares;

    slow_port DUT (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .first_slow_pin(pa),
        .second_slow_pin(pb), .second_pin_out(pout), .second_pin_oe(poe),
        .osc_mode(osc_mode), .crystal_en(xen), .external_slow_clock_in(xclk),
        .slow_ext_interrupt_a(ia), .slow_ext_interrupt_b(ib));

    slow_source far (.sys_clk(sys_clk), .run_clk(run_clk), .lvl(lvl),
        .drv(pout), .drv_oe(poe), .pin_a(pa), .pin_b(pb));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ====================
    // Tasks
    // ====================
    task automatic give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic we, input logic [19:0] adr,
                        input logic [3:0] sel, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            failures++;
            $display("MISMATCH bus answer expected ack seen none");
            give_verdict();
        end
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdr(input logic [19:0] adr);
        xfer(1'b0, adr, 4'h1, 32'h0);
    endtask

    // ====================
    // Tests
    // ====================
    initial begin
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, run_clk} = 4'h0;
        wb_adr_i = '0;
        wb_sel_i = '0;
        wb_dat_i = '0;
        osc_mode = OSC_MODE_INPUT;
        lvl = 2'h3;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdr(ENABLE_ADDR);
        check("enable reset", rd, 32'h0);
        rdr(LEVEL_ADDR);
        check("level disabled", rd, 32'h0);
        $display("test reset done");

        xfer(1'b1, ENABLE_ADDR, 4'h1, 32'h1);
        for (int k = 0; k < 4; k++) begin
            lvl <= k[1:0];
            repeat (4) @(posedge sys_clk);
            rdr(LEVEL_ADDR);
            check("level", rd, {30'h0, k[1:0]});
            check("irq pins", {30'h0, ib, ia}, {30'h0, k[1:0]});
        end
        xfer(1'b1, LEVEL_ADDR, 4'hf, 32'hff);
        rdr(LEVEL_ADDR);
        check("level after write", rd, 32'h3);
        xfer(1'b1, ENABLE_ADDR, 4'h1, 32'ha5);
        xfer(1'b1, ENABLE_ADDR, 4'h0, 32'h0);
        rdr(ENABLE_ADDR);
        check("enable storage", rd, 32'ha5);
        rdr(ENABLE_ADDR + 20'h8);
        check("unmapped err", {31'h0, er}, 32'h1);
        $display("test registers done");

        xfer(1'b1, ENABLE_ADDR, 4'h1, 32'h0);
        osc_mode <= OSC_MODE_CRYSTAL;
        for (int k = 0; k < 2; k++) begin
            lvl <= {1'b0, k[0]};
            repeat (3) @(posedge sys_clk);
            check("crystal on", {30'h0, xen, poe}, 32'h3);
            check("crystal drive", {31'h0, pout}, {31'h0, ~k[0]});
        end
        rdr(LEVEL_ADDR);
        check("level crystal", rd, 32'h0);
        $display("test crystal done");

        osc_mode <= OSC_MODE_EXT_CLK;
        run_clk <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check("ext mode", {29'h0, xen, poe, ia}, 32'h0);
        @(negedge sys_clk);
        p0 = pb;
        for (int k = 0; k < 4; k++) begin
            @(negedge sys_clk);
            check("ext clock", {31'h0, xclk}, {31'h0, pb});
            check("ext toggle", {31'h0, pb}, {31'h0, p0 ^ ~k[0]});
        end
        rdr(LEVEL_ADDR);
        check("level ext", rd, 32'h0);
        run_clk <= 1'b0;
        $display("test ext clock done");
        give_verdict();
    end
endmodule

`default_nettype wire

/* sim/slow_source.sv */
// Far-side model: slow crystal or external slow clock on the two pins
`timescale 1ns/1ns
`default_nettype none

module slow_source (
    // Clock
    input  wire logic       sys_clk,
    // Bench control
    input  wire logic       run_clk,
    input  wire logic [1:0] lvl,
    // Device drive
    input  wire logic       drv,
    input  wire logic       drv_oe,
    // Pins
    output var  logic       pin_a,
    output var  logic       pin_b
);
    logic tick_q = 1'b0;

    // Slow clock stands still unless running
    always_ff @(posedge sys_clk) begin
        tick_q <= run_clk ? ~tick_q : 1'b0;
    end

    always_comb begin
        pin_a = lvl[0];
        pin_b = drv_oe ? drv : (run_clk ? tick_q : lvl[1]);
    end
endmodule

`default_nettype wire

/* verilog/slow_pin_gate.sv */
// Gated, registered level sample of one slow port pin
`timescale 1ns/1ns
`default_nettype none

module slow_pin_gate
    import slow_port_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Pin and gate
    input  wire logic pin,
    input  wire logic enable,
    // Sampled level
    output var  logic level_q
);

    logic level_d;

    // Disabled input reads low
    always_comb begin
        level_d = pin & enable;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_d;
        end
    end

endmodule

`default_nettype wire

/* verilog/slow_port.sv */
// Two-pin slow oscillator input port with classic Wishbone registers
`timescale 1ns/1ns
`default_nettype none

module slow_port
    import slow_port_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [SEL_W-1:0] wb_sel_i,
    input  wire logic [DAT_W-1:0] wb_dat_i,
    output var  logic [DAT_W-1:0] wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  wb_err_o,
    // Pins
    input  wire logic             first_slow_pin,
    input  wire logic             second_slow_pin,
    output var  logic             second_pin_out,
    output var  logic             second_pin_oe,
    // Clock generator side
    input  wire logic [1:0]       osc_mode,
    output var  logic             crystal_en,
    output var  logic             external_slow_clock_in,
    // Interrupt controller side
    output var  logic             slow_ext_interrupt_a,
    output var  logic             slow_ext_interrupt_b
);

    // ========================================================================
    // Bus slave
    // ========================================================================
    bus_state_e       state_q, state_d;
    logic [REG_W-1:0] enable_q, enable_d;
    logic [DAT_W-1:0] dat_q, dat_d;
    logic             err_q, err_d;
    logic [1:0]       level;
    logic             req;
    logic             hit_level;
    logic             hit_enable;

    assign req        = wb_cyc_i & wb_stb_i;
    assign hit_level  = (wb_adr_i == LEVEL_ADDR);
    assign hit_enable = (wb_adr_i == ENABLE_ADDR);

    always_comb begin
        state_d  = state_q;
        enable_d = enable_q;
        dat_d    = dat_q;
        err_d    = 1'b0;
        case (state_q)
            BUS_IDLE: begin
                if (req) begin
                    state_d = BUS_ACK;
                    dat_d   = '0;
                    if (hit_level) begin
                        // Read-only, upper bits zero, writes dropped
                        dat_d[1:0] = level;
                    end else if (hit_enable) begin
                        dat_d[REG_W-1:0] = enable_q;
                        if (wb_we_i && wb_sel_i[0]) begin
                            // All bits stored, bit 0 steers the pins
                            enable_d = wb_dat_i[REG_W-1:0];
                        end
                    end else begin
                        err_d = 1'b1;
                    end
                end
            end
            BUS_ACK: begin
                state_d = BUS_IDLE;
            end
            default: begin
                state_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= BUS_IDLE;
            enable_q <= ENABLE_RESET;
            dat_q    <= '0;
            err_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            enable_q <= enable_d;
            dat_q    <= dat_d;
            err_q    <= err_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = (state_q == BUS_ACK) & ~err_q;
    assign wb_err_o = (state_q == BUS_ACK) & err_q;

    // ========================================================================
    // Pin function selection
    // ========================================================================
    pin_ctrl_s ctrl_q, ctrl_d;
    logic      xtal_drive_d;

    always_comb begin
        ctrl_d.input_en   = enable_q[INPUT_EN_BIT];
        // Oscillator use only while the input function is off
        ctrl_d.crystal_en = (osc_mode == OSC_MODE_CRYSTAL) & ~enable_q[INPUT_EN_BIT];
        ctrl_d.ext_clk_en = (osc_mode == OSC_MODE_EXT_CLK) & ~enable_q[INPUT_EN_BIT];
        // Inverting amplifier across the crystal
        xtal_drive_d      = ~first_slow_pin;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q         <= PIN_CTRL_RESET;
            second_pin_out <= 1'b0;
        end else begin
            ctrl_q         <= ctrl_d;
            second_pin_out <= xtal_drive_d;
        end
    end

    assign second_pin_oe          = ctrl_q.crystal_en;
    assign crystal_en             = ctrl_q.crystal_en;
    assign external_slow_clock_in = second_slow_pin & ctrl_q.ext_clk_en;

    // ========================================================================
    // Level sampling, gated by the input enable
    // ========================================================================
    slow_pin_gate u_first_gate (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin     (first_slow_pin),
        .enable  (ctrl_q.input_en),
        .level_q (level[FIRST_LEVEL_BIT])
    );

    slow_pin_gate u_second_gate (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin     (second_slow_pin),
        .enable  (ctrl_q.input_en),
        .level_q (level[SECOND_LEVEL_BIT])
    );

    // Interrupt use needs only the input function; osc_mode is not decoded
    assign slow_ext_interrupt_a = level[FIRST_LEVEL_BIT];
    assign slow_ext_interrupt_b = level[SECOND_LEVEL_BIT];

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_level_readback: assert property (
        (state_q == BUS_IDLE && req && hit_level) |=> (wb_ack_o && wb_dat_o[1:0] == $past(level)))
        else $error("level read data does not match pins");

    a_level_upper_zero: assert property (
        (state_q == BUS_IDLE && req && hit_level) |=> (wb_dat_o[DAT_W-1:2] == '0))
        else $error("level upper bits not zero");

    a_level_no_write: assert property (
        (state_q == BUS_IDLE && req && hit_level && wb_we_i) |=> $stable(enable_q))
        else $error("level write changed state");

    a_enable_write: assert property (
        (state_q == BUS_IDLE && req && hit_enable && wb_we_i && wb_sel_i[0])
            |=> (enable_q == $past(wb_dat_i[REG_W-1:0])))
        else $error("enable write not stored");

    a_input_gated: assert property (
        !enable_q[INPUT_EN_BIT] [*3] |-> (level == LEVEL_RESET))
        else $error("level seen while input disabled");

    a_crystal_mode: assert property (
        (osc_mode == OSC_MODE_CRYSTAL && !enable_q[INPUT_EN_BIT]) |=> crystal_en)
        else $error("crystal mode not entered");

    a_crystal_drive: assert property (
        crystal_en |-> (second_pin_oe && !ctrl_q.input_en))
        else $error("crystal pin not driven");

    a_ext_clock: assert property (
        (osc_mode == OSC_MODE_EXT_CLK && !enable_q[INPUT_EN_BIT]) |=>
            (ctrl_q.ext_clk_en && !second_pin_oe) ##1 (level[FIRST_LEVEL_BIT] == 1'b0))
        else $error("external clock mode wrong");

    a_spare_storage: assert property (
        (state_q == BUS_IDLE && req && hit_enable && !wb_we_i)
            |=> (wb_dat_o[REG_W-1:1] == $past(enable_q[REG_W-1:1])))
        else $error("spare enable bits lost");

    a_enable_reset: assert property (
        $rose(rst_n) |-> (enable_q == ENABLE_RESET))
        else $error("enable register not zero after reset");

    a_crystal_needs_off: assert property (
        enable_q[INPUT_EN_BIT] |=> !crystal_en)
        else $error("crystal mode while input enabled");

    a_ext_clock_gate: assert property (
        !ctrl_q.ext_clk_en |-> !external_slow_clock_in)
        else $error("external clock passed outside its mode");

endmodule

`default_nettype wire

/* verilog/slow_port_pkg.sv */
// Constants and types for the slow oscillator input port
package slow_port_pkg;

    // ========================================================================
    // Bus geometry
    // ========================================================================
    localparam int          ADR_W            = 20;
    localparam int          DAT_W            = 32;
    localparam int          SEL_W            = 4;

    // ========================================================================
    // Register map: printed index, byte address is four times it
    // ========================================================================
    localparam logic [15:0] LEVEL_IDX        = 16'hf208;
    localparam logic [15:0] ENABLE_IDX       = 16'hf209;
    localparam logic [19:0] LEVEL_ADDR       = {2'h0, LEVEL_IDX, 2'h0};
    localparam logic [19:0] ENABLE_ADDR      = {2'h0, ENABLE_IDX, 2'h0};

    // ========================================================================
    // Fields and reset values
    // ========================================================================
    localparam int          REG_W            = 8;
    localparam int          FIRST_LEVEL_BIT  = 0;
    localparam int          SECOND_LEVEL_BIT = 1;
    localparam int          INPUT_EN_BIT     = 0;
    localparam logic [7:0]  ENABLE_RESET     = 8'h00;
    localparam logic [1:0]  LEVEL_RESET      = 2'h0;

    // ========================================================================
    // Oscillator mode field values
    // ========================================================================
    localparam logic [1:0]  OSC_MODE_CRYSTAL = 2'h1;
    localparam logic [1:0]  OSC_MODE_INPUT   = 2'h2;
    localparam logic [1:0]  OSC_MODE_EXT_CLK = 2'h3;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_e;

    typedef struct packed {
        logic input_en;
        logic crystal_en;
        logic ext_clk_en;
    } pin_ctrl_s;

    localparam pin_ctrl_s   PIN_CTRL_RESET   = '{input_en: 1'b0, crystal_en: 1'b0,
                                                 ext_clk_en: 1'b0};

endpackage
